// File: src/fan_regs_pkg.sv
package fan_regs_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_ACOUSTIC  = 8'h1b;
  localparam logic [7:0] IDX_TRIGGER   = 8'h1c;
  localparam logic [7:0] IDX_INSTALLED = 8'h1d;
  localparam logic [7:0] IDX_PERMIT    = 8'h1e;
  localparam logic [7:0] IDX_DRIVE_CFG = 8'h30;
  localparam logic [7:0] IDX_LOCK_CTRL = 8'h31;
  localparam logic [7:0] IDX_TEST_BUSY = 8'h32;

  localparam int ADDR_W  = 12;
  localparam int FAN_CNT = 8;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int ACU_EN3_BIT   = 0;
  localparam int ACU_EN4_BIT   = 1;
  localparam int ACU_RAMP3_LSB = 2;
  localparam int ACU_RAMP4_LSB = 5;
  localparam int CODE_W        = 3;
  localparam int DRV_STR3_BIT  = 0;
  localparam int DRV_STR4_BIT  = 1;
  localparam int DRV_TO_LSB    = 2;
  localparam int LCK_LOCK_BIT  = 0;
  localparam int LCK_SWRST_BIT = 1;
  localparam logic [7:0] REG_RST = 8'h00;

  // ------------------------------------------------------------
  // Ramp step per time slot, indexed by step code
  // ------------------------------------------------------------
  localparam logic [7:0][7:0] RAMP_STEP_TAB = {8'h30, 8'h18, 8'h0c, 8'h08,
                                              8'h05, 8'h03, 8'h02, 8'h01};
  localparam int STRETCH_FACTOR = 4;

  // ------------------------------------------------------------
  // Timing (125 MHz system clock)
  // ------------------------------------------------------------
  localparam longint CLK_KHZ     = 125000;
  localparam longint SLOT_MS     = 220;
  localparam logic [31:0] SLOT_CYC_DEF = 32'(SLOT_MS * CLK_KHZ);
  localparam longint TO_MS_1 = 100;
  localparam longint TO_MS_2 = 250;
  localparam longint TO_MS_3 = 400;
  localparam longint TO_MS_4 = 667;
  localparam longint TO_MS_5 = 1000;
  localparam longint TO_MS_6 = 2000;
  localparam longint TO_MS_7 = 32000;
  // Code 0 means no timeout: the test ends after one cycle
  localparam logic [7:0][31:0] TIMEOUT_CYC_DEF = {
    32'(TO_MS_7 * CLK_KHZ), 32'(TO_MS_6 * CLK_KHZ), 32'(TO_MS_5 * CLK_KHZ),
    32'(TO_MS_4 * CLK_KHZ), 32'(TO_MS_3 * CLK_KHZ), 32'(TO_MS_2 * CLK_KHZ),
    32'(TO_MS_1 * CLK_KHZ), 32'h0000_0001};

endpackage

// File: src/ramp_step_unit.sv
`timescale 1ns/1ps
`default_nettype none
module ramp_step_unit
  import fan_regs_pkg::*;
#(
  parameter logic [31:0] P_SLOT_CYC = SLOT_CYC_DEF
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  input  wire logic              i_enable,
  input  wire logic [CODE_W-1:0] i_step_code,
  input  wire logic              i_stretch,
  input  wire logic [7:0]        i_target,
  output var  logic [7:0]        o_duty
);

  logic [31:0] slot_cnt_reg;
  logic [31:0] slot_len;
  logic [7:0]  step;
  logic        slot_end;

  // Slot length, four times longer when stretched
  assign slot_len = i_stretch ? 32'(P_SLOT_CYC * STRETCH_FACTOR) : P_SLOT_CYC;
  assign step     = RAMP_STEP_TAB[i_step_code];
  assign slot_end = (slot_cnt_reg >= slot_len - 32'h0000_0001);

  // Time slot counter
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_enable || slot_end) begin
      slot_cnt_reg <= 32'h0000_0000;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 32'h0000_0001;
    end
  end

  // Duty follows target directly, or one step per slot
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_duty <= 8'h00;
    end else if (!i_enable) begin
      o_duty <= i_target;
    end else if (slot_end) begin
      if (o_duty < i_target) begin
        o_duty <= (i_target - o_duty > step) ? o_duty + step : i_target;
      end else if (o_duty > i_target) begin
        o_duty <= (o_duty - i_target > step) ? o_duty - step : i_target;
      end
    end
  end

endmodule // ramp_step_unit
`default_nettype wire

// File: src/freewheel_timer.sv
`timescale 1ns/1ps
`default_nettype none
module freewheel_timer (
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  input  wire logic        i_run,
  input  wire logic [31:0] i_load_cyc,
  output var  logic        o_busy,
  output var  logic        o_done
);

  logic [31:0] cnt_reg;

  // Start on run, count down, pulse done; dropping run aborts
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_run) begin
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
      cnt_reg <= 32'h0000_0000;
    end else if (!o_busy && !o_done) begin
      o_busy  <= 1'b1;
      o_done  <= 1'b0;
      cnt_reg <= (i_load_cyc == 32'h0000_0000) ? 32'h0000_0001 : i_load_cyc;
    end else if (o_busy && cnt_reg == 32'h0000_0001) begin
      o_busy  <= 1'b0;
      o_done  <= 1'b1;
      cnt_reg <= 32'h0000_0000;
    end else if (o_busy) begin
      cnt_reg <= cnt_reg - 32'h0000_0001;
      o_done  <= 1'b0;
    end else begin
      o_done  <= 1'b0;
    end
  end

endmodule // freewheel_timer
`default_nettype wire

// File: src/fan_acoustics_freewheel_regs.sv
// Summary of operation
// RULE1 - Channel 3 acoustic enable bit 0 turns duty ramping on for drive 3.
// RULE2 - Channel 4 acoustic enable bit 1 turns duty ramping on for drive 4.
// RULE3 - Channel 3 step code bits 4:2, reset zero, steps 1..48 per slot.
// RULE4 - Channel 4 step code bits 7:5, reset zero, selects drive 4 step.
// RULE5 - Device clears each test trigger bit when that fan's test ends.
// RULE6 - Trigger register bit 0 is fan 1 up to bit 7 for fan 8.
// RULE7 - Software marks each installed fan, bit 0 fan 1 to bit 7 fan 8.
// RULE8 - Permit bit set allows the freewheeling test for the matching fan.
// RULE9 - All four registers reset to zero, also by soft reset, and lockable.
// RULE10 - Stretch bit makes the acoustic ramp four times slower.
// RULE11 - Test length comes from the 3-bit timeout code, none up to 32 s.
// RULE12 - After lock, writes are ignored and reads still return stored values; a soft reset write to the lock register still clears the registers.
// RULE13 - Trigger without permit is cleared without running any test.
`timescale 1ns/1ps
`default_nettype none
module fan_acoustics_freewheel_regs
  import fan_regs_pkg::*;
#(
  parameter logic [31:0]      P_SLOT_CYC    = SLOT_CYC_DEF,
  parameter logic [7:0][31:0] P_TIMEOUT_CYC = TIMEOUT_CYC_DEF
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output var  logic [31:0]       o_prdata,
  output var  logic              o_pready,
  output var  logic              o_pslverr,
  input  wire logic [7:0]        i_duty_target_ch3,
  input  wire logic [7:0]        i_duty_target_ch4,
  output var  logic [7:0]        o_duty_ch3,
  output var  logic [7:0]        o_duty_ch4,
  output var  logic [7:0]        o_freewheel_active,
  output var  logic [7:0]        o_fan_installed
);

  // ------------------------------------------------------------
  // Registers and decode
  // ------------------------------------------------------------
  logic [7:0] acoustic_ramp_ctrl_ch34_reg;
  logic [7:0] freewheel_test_trigger_reg;
  logic [7:0] fan_installed_flags_reg;
  logic [7:0] freewheel_test_permit_reg;
  logic [7:0] drive_cfg_reg;
  logic       lock_reg;
  logic       soft_rst_reg;
  logic [7:0] fan_done;
  logic [7:0] fan_busy;
  logic [7:0] fan_run;
  logic [7:0] rd_byte;
  logic       acc;
  logic       wr;
  logic       wr_ok;
  logic       mapped;
  logic [7:0] idx;
  logic       acoustic_enable_ch3;
  logic       acoustic_enable_ch4;
  logic       regs_rst;

  // APB access phase and index decode
  assign acc    = i_psel && i_penable && o_pready;
  assign wr     = acc && i_pwrite && mapped;
  assign wr_ok  = wr && !lock_reg; // RULE12
  assign idx    = i_paddr[9:2];
  // Misaligned or out-of-range addresses never alias onto a register
  assign mapped = (i_paddr[1:0] == 2'b00) && (i_paddr[ADDR_W-1:10] == 2'b00) &&
                  (idx == IDX_ACOUSTIC || idx == IDX_TRIGGER ||
                   idx == IDX_INSTALLED || idx == IDX_PERMIT ||
                   idx == IDX_DRIVE_CFG || idx == IDX_LOCK_CTRL ||
                   idx == IDX_TEST_BUSY);
  assign regs_rst = i_sys_rst || soft_rst_reg; // RULE9

  assign acoustic_enable_ch3 = acoustic_ramp_ctrl_ch34_reg[ACU_EN3_BIT];
  assign acoustic_enable_ch4 = acoustic_ramp_ctrl_ch34_reg[ACU_EN4_BIT];

  // ------------------------------------------------------------
  // APB slave: one wait-free access phase after setup
  // ------------------------------------------------------------
  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_ACOUSTIC:  rd_byte = acoustic_ramp_ctrl_ch34_reg;
      IDX_TRIGGER:   rd_byte = freewheel_test_trigger_reg;
      IDX_INSTALLED: rd_byte = fan_installed_flags_reg;
      IDX_PERMIT:    rd_byte = freewheel_test_permit_reg;
      IDX_DRIVE_CFG: rd_byte = drive_cfg_reg;
      IDX_LOCK_CTRL: rd_byte = {7'h00, lock_reg};
      IDX_TEST_BUSY: rd_byte = fan_busy;
      default:       rd_byte = 8'h00;
    endcase
  end

  // Ready, read data and error prepared in the setup cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !mapped;
      o_prdata  <= (i_psel && !i_penable && !i_pwrite && mapped) ?
                   {24'h00_0000, rd_byte} : 32'h0000_0000; // RULE12
    end
  end

  // ------------------------------------------------------------
  // Lock and soft reset control
  // ------------------------------------------------------------
  // Lock sets once and holds until power-on reset
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      lock_reg <= 1'b0;
    end else if (wr && idx == IDX_LOCK_CTRL && i_pwdata[LCK_LOCK_BIT]) begin
      lock_reg <= 1'b1; // RULE12
    end
  end

  // Soft reset pulse, one cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr && idx == IDX_LOCK_CTRL && i_pwdata[LCK_SWRST_BIT];
    end
  end

  // ------------------------------------------------------------
  // Plain control registers
  // ------------------------------------------------------------
  // Acoustic enables and step codes
  always_ff @(posedge i_clk_sys) begin
    if (regs_rst) begin
      acoustic_ramp_ctrl_ch34_reg <= REG_RST; // RULE9
    end else if (wr_ok && idx == IDX_ACOUSTIC) begin
      acoustic_ramp_ctrl_ch34_reg <= i_pwdata[7:0]; // RULE3 RULE4
    end
  end

  // Installed fan flags
  always_ff @(posedge i_clk_sys) begin
    if (regs_rst) begin
      fan_installed_flags_reg <= REG_RST; // RULE9
    end else if (wr_ok && idx == IDX_INSTALLED) begin
      fan_installed_flags_reg <= i_pwdata[7:0]; // RULE7
    end
  end

  // Test permits
  always_ff @(posedge i_clk_sys) begin
    if (regs_rst) begin
      freewheel_test_permit_reg <= REG_RST; // RULE9
    end else if (wr_ok && idx == IDX_PERMIT) begin
      freewheel_test_permit_reg <= i_pwdata[7:0]; // RULE8
    end
  end

  // Stretch bits and test timeout code
  always_ff @(posedge i_clk_sys) begin
    if (regs_rst) begin
      drive_cfg_reg <= REG_RST;
    end else if (wr_ok && idx == IDX_DRIVE_CFG) begin
      drive_cfg_reg <= i_pwdata[7:0];
    end
  end

  // Installed flags out
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_fan_installed <= 8'h00;
    end else begin
      o_fan_installed <= fan_installed_flags_reg;
    end
  end

  // ------------------------------------------------------------
  // Freewheeling test per fan
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < FAN_CNT; g++) begin : g_fan
      logic set_bit;
      assign set_bit  = wr_ok && idx == IDX_TRIGGER && i_pwdata[g]; // RULE6
      assign fan_run[g] = freewheel_test_trigger_reg[g] &&
                          freewheel_test_permit_reg[g]; // RULE13

      // Trigger bit: software set wins over hardware clear
      always_ff @(posedge i_clk_sys) begin
        if (regs_rst) begin
          freewheel_test_trigger_reg[g] <= 1'b0; // RULE9
        end else if (set_bit) begin
          freewheel_test_trigger_reg[g] <= 1'b1;
        end else if (wr_ok && idx == IDX_TRIGGER) begin
          freewheel_test_trigger_reg[g] <= 1'b0;
        end else if (fan_done[g]) begin
          freewheel_test_trigger_reg[g] <= 1'b0; // RULE5
        end else if (!freewheel_test_permit_reg[g]) begin
          freewheel_test_trigger_reg[g] <= 1'b0; // RULE13
        end
      end

      freewheel_timer u_timer (
        .i_clk_sys  (i_clk_sys),
        .i_sys_rst  (regs_rst),
        .i_run      (fan_run[g]),
        .i_load_cyc (P_TIMEOUT_CYC[drive_cfg_reg[DRV_TO_LSB +: CODE_W]]), // RULE11
        .o_busy     (fan_busy[g]),
        .o_done     (fan_done[g])
      );
    end
  endgenerate

  assign o_freewheel_active = fan_busy;

  // ------------------------------------------------------------
  // Acoustic ramps for drives 3 and 4
  // ------------------------------------------------------------
  ramp_step_unit #(
    .P_SLOT_CYC (P_SLOT_CYC)
  ) u_ramp_ch3 (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_enable    (acoustic_enable_ch3), // RULE1
    .i_step_code (acoustic_ramp_ctrl_ch34_reg[ACU_RAMP3_LSB +: CODE_W]), // RULE3
    .i_stretch   (drive_cfg_reg[DRV_STR3_BIT]), // RULE10
    .i_target    (i_duty_target_ch3),
    .o_duty      (o_duty_ch3)
  );

  ramp_step_unit #(
    .P_SLOT_CYC (P_SLOT_CYC)
  ) u_ramp_ch4 (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_enable    (acoustic_enable_ch4), // RULE2
    .i_step_code (acoustic_ramp_ctrl_ch34_reg[ACU_RAMP4_LSB +: CODE_W]), // RULE4
    .i_stretch   (drive_cfg_reg[DRV_STR4_BIT]), // RULE10
    .i_target    (i_duty_target_ch4),
    .o_duty      (o_duty_ch4)
  );

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_trig_write(int b);
    wr_ok && idx == IDX_TRIGGER && i_pwdata[b];
  endsequence

  a_ch3_off_follow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // RULE1
    !acoustic_enable_ch3 && $stable(acoustic_enable_ch3) |=> o_duty_ch3 == $past(i_duty_target_ch3))
    else $error("drive 3 does not follow target with ramp off");

  a_ch4_off_follow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // RULE2
    !acoustic_enable_ch4 && $stable(acoustic_enable_ch4) |=> o_duty_ch4 == $past(i_duty_target_ch4))
    else $error("drive 4 does not follow target with ramp off");

  a_ch3_step_max: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // RULE3
    acoustic_enable_ch3 && $past(acoustic_enable_ch3) |->
      (o_duty_ch3 - $past(o_duty_ch3) <= RAMP_STEP_TAB[$past(acoustic_ramp_ctrl_ch34_reg[4:2])]) ||
      ($past(o_duty_ch3) - o_duty_ch3 <= RAMP_STEP_TAB[$past(acoustic_ramp_ctrl_ch34_reg[4:2])]))
    else $error("drive 3 ramp step too large");

  a_ch4_step_reg: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // RULE4
    wr_ok && idx == IDX_ACOUSTIC |=> acoustic_ramp_ctrl_ch34_reg[7:5] == $past(i_pwdata[7:5]))
    else $error("drive 4 step code not stored");

  a_done_clears: assert property (@(posedge i_clk_sys) disable iff (regs_rst) // RULE5
    fan_done[0] && !(wr_ok && idx == IDX_TRIGGER && i_pwdata[0]) |=> !freewheel_test_trigger_reg[0])
    else $error("trigger bit not cleared after test");

  a_trig_bit_map: assert property (@(posedge i_clk_sys) disable iff (regs_rst) // RULE6
    s_trig_write(7) |=> freewheel_test_trigger_reg[7])
    else $error("trigger bit 7 not set by write");

  a_permit_run: assert property (@(posedge i_clk_sys) disable iff (regs_rst) // RULE8
    fan_run[2] && !fan_busy[2] && !fan_done[2] |=> fan_busy[2])
    else $error("permitted test did not start");

  a_reset_zero: assert property (@(posedge i_clk_sys) // RULE9
    $past(regs_rst) |-> acoustic_ramp_ctrl_ch34_reg == 8'h00 &&
      freewheel_test_trigger_reg == 8'h00 && fan_installed_flags_reg == 8'h00 &&
      freewheel_test_permit_reg == 8'h00)
    else $error("registers not zero after reset");

  a_lock_holds: assert property (@(posedge i_clk_sys) disable iff (regs_rst) // RULE12
    lock_reg && wr |=> $stable(freewheel_test_permit_reg) &&
      $stable(fan_installed_flags_reg) && $stable(acoustic_ramp_ctrl_ch34_reg))
    else $error("locked register changed");

  a_no_permit: assert property (@(posedge i_clk_sys) disable iff (regs_rst) // RULE13
    freewheel_test_trigger_reg[0] && !freewheel_test_permit_reg[0] && !wr_ok
      |=> !freewheel_test_trigger_reg[0] && !fan_busy[0])
    else $error("trigger without permit not cleared");

endmodule // fan_acoustics_freewheel_regs
`default_nettype wire

// File: bench/fan_model.sv
`timescale 1ns/1ps
`default_nettype none
module fan_model (
  input  wire logic [7:0]  i_duty_ch4,
  input  wire logic        i_clk_sys,
  input  wire logic [7:0]  i_freewheel,
  output var  logic [31:0] o_tests,
  output var  logic [31:0] o_last_len,
  output var  logic [15:0] o_speed_ch4
);
  logic [7:0]  fw_prev;
  logic [31:0] run_len;

  initial begin
    fw_prev = 8'h00;
    run_len = 32'h0;
    o_tests = 32'h0;
    o_last_len = 32'h0;
    o_speed_ch4 = 16'h0000;
  end

  // ------------------------------------------------------------
  // Released drive: count tests and time spent coasting
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    fw_prev <= i_freewheel;
    if (|(i_freewheel & ~fw_prev)) o_tests <= o_tests + 32'h1;
    if (|i_freewheel) begin
      run_len <= run_len + 32'h1;
    end else if (|fw_prev) begin
      o_last_len <= run_len;
      run_len <= 32'h0;
    end
  end

  // Rotor lags the drive, coasts down while released
  always @(posedge i_clk_sys) begin
    if (|i_freewheel) o_speed_ch4 <= o_speed_ch4 - (o_speed_ch4 >> 4);
    else o_speed_ch4 <= o_speed_ch4 + {8'h00, i_duty_ch4} - (o_speed_ch4 >> 4);
  end
endmodule // fan_model
`default_nettype wire

// File: bench/fan_acoustics_freewheel_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module fan_acoustics_freewheel_regs_bench;
  import fan_regs_pkg::*;
  localparam logic [31:0]      SLOT = 32'h0000_000a;
  localparam logic [7:0][31:0] TOUT = {32'h50, 32'h46, 32'h3c, 32'h32,
                                       32'h28, 32'h1e, 32'h14, 32'h01};
  localparam logic [3:0][7:0]  REGS = {IDX_PERMIT, IDX_INSTALLED, IDX_TRIGGER, IDX_ACOUSTIC};
  logic              clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, tests, last_len, t0;
  logic [7:0]        tgt3, tgt4, duty3, duty4, active, installed, d0;
  int                num_errors = 0;
  int                check_count = 0;

  fan_acoustics_freewheel_regs #(.P_SLOT_CYC(SLOT), .P_TIMEOUT_CYC(TOUT))
    i_fan_acoustics_freewheel_regs (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_duty_target_ch3(tgt3),
    .i_duty_target_ch4(tgt4), .o_duty_ch3(duty3), .o_duty_ch4(duty4),
    .o_freewheel_active(active), .o_fan_installed(installed));

  fan_model i_fan_model (
    .i_clk_sys(clk), .i_freewheel(active), .i_duty_ch4(duty4), .o_tests(tests),
    .o_last_len(last_len), .o_speed_ch4());

  // ------------------------------------------------------------
  // Clock, verdict and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Bus master tasks
  // ------------------------------------------------------------
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    `CHK("wait states", 1, n)
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(idx, 1'b1, d, r, e);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(idx, 1'b0, 8'h00, r, e);
    `CHK(nm, {24'h000000, exp}, r)
    `CHK("pslverr", 1'b0, e)
  endtask

  // Bounded wait for a test-active pattern
  task automatic wait_act(input logic [7:0] exp);
    int n;
    n = 0;
    while (active !== exp && n < 200) begin
      @(posedge clk);
      n++;
    end
    `CHK("active", exp, active)
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin : main
    logic [31:0] r;
    logic        e;
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; tgt3 = 8'h00; tgt4 = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd_chk("reset value", REGS[i], 8'h00);
    wr(IDX_ACOUSTIC, 8'ha4);
    rd_chk("acoustic", IDX_ACOUSTIC, 8'ha4);
    tgt3 <= 8'h22;
    tgt4 <= 8'h77;
    repeat (3) @(posedge clk);
    #1 `CHK("duty3 off", 8'h22, duty3)
    `CHK("duty4 off", 8'h77, duty4)
    @(posedge clk) tgt3 <= 8'h00;
    tgt4 <= 8'h00;
    wr(IDX_ACOUSTIC, 8'h1f);
    @(posedge clk) tgt3 <= 8'hc0;
    tgt4 <= 8'hff;
    repeat (25) @(posedge clk);
    #1 `CHK("duty3 step", 1'b1, duty3 % 8'h30 == 8'h00 && duty3 != 8'h00 && duty3 < 8'hc0)
    repeat (60) @(posedge clk);
    #1 `CHK("duty3 clamp", 8'hc0, duty3)
    d0 = duty4;
    repeat (200) @(posedge clk);
    #1 `CHK("duty4 rate", 1'b1, (duty4 - d0) inside {[8'd19:8'd21]})
    wr(IDX_DRIVE_CFG, 8'h02);
    d0 = duty4;
    repeat (200) @(posedge clk);
    #1 `CHK("duty4 slow", 1'b1, (duty4 - d0) inside {[8'd4:8'd6]})
    wr(IDX_ACOUSTIC, 8'h00);
    wr(IDX_DRIVE_CFG, 8'h08);
    wr(IDX_PERMIT, 8'hff);
    wr(IDX_INSTALLED, 8'h81);
    rd_chk("installed", IDX_INSTALLED, 8'h81);
    `CHK("installed out", 8'h81, installed)
    for (int n = 0; n < 8; n++) begin
      wr(IDX_TRIGGER, 8'h01 << n);
      rd_chk("trigger set", IDX_TRIGGER, 8'h01 << n);
      wait_act(8'h01 << n);
      wait_act(8'h00);
      repeat (3) @(posedge clk);
      `CHK("test length", TOUT[2], last_len)
      rd_chk("trigger clear", IDX_TRIGGER, 8'h00);
    end
    wr(IDX_PERMIT, 8'hfe);
    t0 = tests;
    wr(IDX_TRIGGER, 8'h01);
    rd_chk("trigger refused", IDX_TRIGGER, 8'h00);
    repeat (5) @(posedge clk);
    `CHK("tests run", t0, tests)
    apb(8'h20, 1'b0, 8'h00, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    wr(IDX_ACOUSTIC, 8'h5a);
    wr(IDX_TRIGGER, 8'h80);
    wr(IDX_LOCK_CTRL, 8'h02);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) rd_chk("soft reset", REGS[i], 8'h00);
    wr(IDX_INSTALLED, 8'h3c);
    wr(IDX_LOCK_CTRL, 8'h01);
    wr(IDX_INSTALLED, 8'hff);
    rd_chk("locked", IDX_INSTALLED, 8'h3c);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk("por", IDX_INSTALLED, 8'h00);
    wr(IDX_INSTALLED, 8'h55);
    rd_chk("unlocked", IDX_INSTALLED, 8'h55);
    tally_and_finish();
  end
endmodule // fan_acoustics_freewheel_regs_bench
`default_nettype wire
